// [icfi_top.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_top #(
    parameter int unsigned NAK_TIMEOUT_CYC = icfi_pkg::NAK_TIMEOUT_CYC
) (
    input  wire logic                             clk,
    input  wire logic                             rstn,
    input  wire icfi_pkg::icfi_bus_t              bus,
    output logic      [31:0]                      rd_data,
    input  wire icfi_pkg::icfi_byte_t             rx,
    output logic                                  tx_valid,
    output logic      [7:0]                       tx_data,
    input  wire logic                             tx_ready,
    input  wire logic [11:0]                      digital_input_points,
    input  wire icfi_pkg::icfi_ana_t [3:0]        analogue_input_channels,
    input  wire logic [9:0][2:0]                  output_wait_code,
    output logic      [9:0]                       output_points
);

    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [4:0] {
        R_IDLE = 5'b00001,
        R_LENH = 5'b00010,
        R_LENL = 5'b00100,
        R_BODY = 5'b01000,
        R_LF   = 5'b10000
    } icfi_rx_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b01,
        T_SEND = 2'b10
    } icfi_tx_t;

    icfi_rx_t   rx_st;
    icfi_tx_t   tx_st;
    logic [7:0] len_hi;
    logic [7:0] len_lo;
    logic [7:0] hold0;
    logic [7:0] hold1;
    logic [7:0] rx_xor;
    logic [7:0] rx_cnt;
    logic [7:0] rbuf [icfi_pkg::BUF_DEPTH];
    logic [31:0] tmo_cnt;
    logic [11:0] din_s1;
    logic [11:0] din_s2;
    logic [1:0] ctrl;
    logic [2:0] stat;
    logic       pend_nak;
    logic       pend_state;
    logic       tx_is_nak;
    logic [7:0] tx_idx;
    logic [7:0] tx_xor;
    logic [7:0] snap [icfi_pkg::STATE_DATA_LEN];
    logic [7:0] rep  [icfi_pkg::STATE_DATA_LEN];

    // ****************************************
    // input synchroniser
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_s1 <= 12'h000;
            din_s2 <= 12'h000;
        end else begin
            din_s1 <= digital_input_points;
            din_s2 <= din_s1;
        end
    end

    // ****************************************
    // receive decode
    // ****************************************
    logic [3:0] lh_n;
    logic [3:0] ll_n;
    logic [3:0] ch_n;
    logic [3:0] cl_n;
    logic       lh_ok;
    logic       ll_ok;
    logic       ch_ok;
    logic       cl_ok;

    icfi_hex2nib u_len_hi (.ch(len_hi), .nib(lh_n), .ok(lh_ok));
    icfi_hex2nib u_len_lo (.ch(len_lo), .nib(ll_n), .ok(ll_ok));
    icfi_hex2nib u_chk_hi (.ch(hold1),  .nib(ch_n), .ok(ch_ok));
    icfi_hex2nib u_chk_lo (.ch(hold0),  .nib(cl_n), .ok(cl_ok));

    wire       rx_byte   = rx.valid;
    wire       got_lf    = (rx_st == R_LF) && rx_byte;
    wire       lf_good   = rx.data == icfi_pkg::CH_LF;
    wire [7:0] body_n    = rx_cnt - 8'd2;
    wire       chk_good  = ch_ok && cl_ok && ({ch_n, cl_n} == rx_xor) && (rx_cnt >= 8'd2);
    wire       len_good  = lh_ok && ll_ok && ({lh_n, ll_n} == body_n) && lf_good;
    wire       ev_chk    = got_lf && !chk_good;
    wire       ev_len    = got_lf && chk_good && !len_good;
    wire       timed_out = (rx_st != R_IDLE) && (tmo_cnt >= NAK_TIMEOUT_CYC - 1);
    wire       accept    = got_lf && chk_good && len_good;
    wire       is_batch  = accept && (body_n == icfi_pkg::BATCH_BODY_LEN)
                           && (rbuf[0] == icfi_pkg::CH_0) && (rbuf[1] == icfi_pkg::CH_1)
                           && (rbuf[icfi_pkg::SEP_IDX] == icfi_pkg::CH_SEP);

    logic [9:0] next_out;
    always_comb begin
        next_out = output_points;
        for (int p = 0; p < icfi_pkg::NUM_OUT; p++) begin
            if (rbuf[icfi_pkg::MASK_BASE + p] == icfi_pkg::CH_1) begin
                next_out[p] = rbuf[icfi_pkg::STATE_BASE + p] == icfi_pkg::CH_1;
            end
        end
    end

    // ****************************************
    // receive sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_st   <= R_IDLE;
            len_hi  <= 8'h00;
            len_lo  <= 8'h00;
            hold0   <= 8'h00;
            hold1   <= 8'h00;
            rx_xor  <= 8'h00;
            rx_cnt  <= 8'h00;
            tmo_cnt <= 32'h0;
        end else if (timed_out) begin
            rx_st <= R_IDLE;
        end else if (rx_byte) begin
            case (rx_st)
                R_IDLE: begin
                    if (rx.data == icfi_pkg::CH_SOF) begin
                        rx_st   <= R_LENH;
                        rx_xor  <= icfi_pkg::CH_SOF;
                        tmo_cnt <= 32'h0;
                    end
                end
                R_LENH: begin
                    len_hi <= rx.data;
                    rx_xor <= rx_xor ^ rx.data;
                    rx_st  <= R_LENL;
                end
                R_LENL: begin
                    len_lo <= rx.data;
                    rx_xor <= rx_xor ^ rx.data;
                    hold0  <= 8'h00;
                    hold1  <= 8'h00;
                    rx_cnt <= 8'h00;
                    rx_st  <= R_BODY;
                end
                R_BODY: begin
                    if (rx.data == icfi_pkg::CH_CR) begin
                        rx_st <= R_LF;
                    end else begin
                        // the last two body bytes are the check pair, so each byte joins the sum two bytes late and those two never do
                        rx_xor <= rx_xor ^ hold1;
                        hold1  <= hold0;
                        hold0  <= rx.data;
                        if (rx_cnt != 8'hFF) begin
                            rx_cnt <= rx_cnt + 8'd1;
                        end
                    end
                end
                R_LF: begin
                    rx_st <= R_IDLE;
                end
                default: begin
                    rx_st <= R_IDLE;
                end
            endcase
            if (rx_st != R_IDLE) begin
                tmo_cnt <= tmo_cnt + 32'h1;
            end
        end else if (rx_st != R_IDLE) begin
            tmo_cnt <= tmo_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rx_byte && (rx_st == R_BODY) && (rx.data != icfi_pkg::CH_CR)
            && (rx_cnt < 8'(icfi_pkg::BUF_DEPTH))) begin
            rbuf[rx_cnt[4:0]] <= rx.data;
        end
    end

    // ****************************************
    // state reply image
    // ****************************************
    wire [7:0] ctrl_code = ctrl[icfi_pkg::CTRL_ABN] ? icfi_pkg::CH_9 :
                           !ctrl[icfi_pkg::CTRL_RUN] ? icfi_pkg::CH_1 : icfi_pkg::CH_0;

    always_comb begin
        for (int i = 0; i < icfi_pkg::STATE_DATA_LEN; i++) begin
            rep[i] = icfi_pkg::CH_SEP;
        end
        rep[0] = ctrl_code;
        for (int c = 0; c < icfi_pkg::NUM_ANA; c++) begin
            rep[icfi_pkg::ANA_BASE + icfi_pkg::ANA_STRIDE * c] =
                analogue_input_channels[c].level_mode ? icfi_pkg::CH_9 :
                analogue_input_channels[c].switch_on  ? icfi_pkg::CH_1 : icfi_pkg::CH_0;
            rep[icfi_pkg::ANA_BASE + icfi_pkg::ANA_STRIDE * c + 1] =
                8'(icfi_pkg::CH_0 + analogue_input_channels[c].level / 10'd1000);
            rep[icfi_pkg::ANA_BASE + icfi_pkg::ANA_STRIDE * c + 2] =
                8'(icfi_pkg::CH_0 + (analogue_input_channels[c].level / 10'd100) % 10'd10);
            rep[icfi_pkg::ANA_BASE + icfi_pkg::ANA_STRIDE * c + 3] =
                8'(icfi_pkg::CH_0 + (analogue_input_channels[c].level / 10'd10) % 10'd10);
            rep[icfi_pkg::ANA_BASE + icfi_pkg::ANA_STRIDE * c + 4] =
                8'(icfi_pkg::CH_0 + analogue_input_channels[c].level % 10'd10);
        end
        for (int i = 0; i < icfi_pkg::NUM_IN; i++) begin
            rep[icfi_pkg::IN_BASE + i + i / 4] = din_s2[i] ? icfi_pkg::CH_1 : icfi_pkg::CH_0;
        end
        for (int p = 0; p < icfi_pkg::NUM_OUT; p++) begin
            // a pending timed or conditional action masks the plain level
            rep[icfi_pkg::OUT_BASE + p + p / 4] = (output_wait_code[p] != 3'h0) ?
                (icfi_pkg::CH_0 + {5'h00, output_wait_code[p]}) :
                (output_points[p] ? icfi_pkg::CH_1 : icfi_pkg::CH_0);
        end
    end

    // ****************************************
    // transmit byte selection
    // ****************************************
    wire [7:0] tx_len  = tx_is_nak ? icfi_pkg::NAK_LEN : icfi_pkg::STATE_LEN;
    wire [7:0] tx_n    = tx_idx + 8'd1;
    wire [7:0] tx_k    = tx_n - 8'd3;
    wire [7:0] snap_i  = tx_k - 8'd2;
    wire [7:0] xor_sum = (tx_idx <= tx_len + 8'd2) ? (tx_xor ^ tx_data) : tx_xor;
    wire [7:0] len_hc;
    wire [7:0] len_lc;
    wire [7:0] chk_hc;
    wire [7:0] chk_lc;

    icfi_nib2hex u_tlen_hi (.nib(tx_len[7:4]),  .ch(len_hc));
    icfi_nib2hex u_tlen_lo (.nib(tx_len[3:0]),  .ch(len_lc));
    icfi_nib2hex u_tchk_hi (.nib(xor_sum[7:4]), .ch(chk_hc));
    icfi_nib2hex u_tchk_lo (.nib(xor_sum[3:0]), .ch(chk_lc));

    wire [7:0] nak_body = (tx_k == 8'd2) ? icfi_pkg::CH_N :
                          (tx_k == 8'd3) ? icfi_pkg::CH_A :
                          (tx_k == 8'd4) ? icfi_pkg::CH_K : icfi_pkg::CH_0;
    wire [7:0] st_body  = (tx_k == 8'd0) ? icfi_pkg::CH_0 :
                          (tx_k == 8'd1) ? icfi_pkg::CH_2 : snap[snap_i[5:0]];
    wire [7:0] next_tx  = (tx_n == 8'd1) ? len_hc :
                          (tx_n == 8'd2) ? len_lc :
                          (tx_n <= tx_len + 8'd2) ? (tx_is_nak ? nak_body : st_body) :
                          (tx_n == tx_len + 8'd3) ? chk_hc :
                          (tx_n == tx_len + 8'd4) ? chk_lc :
                          (tx_n == tx_len + 8'd5) ? icfi_pkg::CH_CR : icfi_pkg::CH_LF;
    wire       tx_take  = tx_valid && tx_ready;
    wire       tx_last  = tx_idx == tx_len + 8'd6;
    wire       tx_start = (tx_st == T_IDLE) && (pend_nak || pend_state);

    // ****************************************
    // transmit sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_st     <= T_IDLE;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
            tx_idx    <= 8'h00;
            tx_xor    <= 8'h00;
            tx_is_nak <= 1'b0;
        end else begin
            case (tx_st)
                T_IDLE: begin
                    if (tx_start) begin
                        tx_st     <= T_SEND;
                        tx_valid  <= 1'b1;
                        tx_data   <= icfi_pkg::CH_SOF;
                        tx_idx    <= 8'h00;
                        tx_xor    <= 8'h00;
                        tx_is_nak <= pend_nak;
                    end
                end
                T_SEND: begin
                    if (tx_take) begin
                        if (tx_idx <= tx_len + 8'd2) begin
                            tx_xor <= tx_xor ^ tx_data;
                        end
                        if (tx_last) begin
                            tx_valid <= 1'b0;
                            tx_st    <= T_IDLE;
                        end else begin
                            tx_data <= next_tx;
                            tx_idx  <= tx_n;
                        end
                    end
                end
                default: begin
                    tx_st <= T_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (tx_start) begin
            snap <= rep;
        end
    end

    // ****************************************
    // outputs, pending replies, registers
    // ****************************************
    wire wr_ctrl = bus.wr && (bus.addr == icfi_pkg::REG_CTRL);
    wire wr_stat = bus.wr && (bus.addr == icfi_pkg::REG_STAT);
    wire [2:0] stat_set = {timed_out, ev_len, ev_chk};
    wire [31:0] rd_mux = (bus.addr == icfi_pkg::REG_CTRL) ? {30'h0, ctrl} :
                         (bus.addr == icfi_pkg::REG_OUT)  ? {22'h0, output_points} :
                         (bus.addr == icfi_pkg::REG_STAT) ? {22'h0, tx_st == T_SEND, rx_st != R_IDLE, 5'h00, stat} :
                         32'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            output_points <= 10'h000;
            pend_nak      <= 1'b0;
            pend_state    <= 1'b0;
            ctrl          <= icfi_pkg::CTRL_RESET;
            stat          <= 3'h0;
            rd_data       <= 32'h0;
        end else begin
            if (is_batch) begin
                output_points <= next_out;
            end
            pend_nak   <= (pend_nak && !(tx_start && pend_nak)) || ev_chk || ev_len || timed_out;
            pend_state <= (pend_state && !(tx_start && !pend_nak)) || is_batch;
            if (wr_ctrl) begin
                ctrl <= bus.wdata[1:0];
            end
            stat <= (wr_stat ? (stat & ~bus.wdata[2:0]) : stat) | stat_set;
            rd_data <= bus.rd ? rd_mux : 32'h0;
        end
    end

endmodule
`default_nettype wire

// [icfi_pkg.sv]
package icfi_pkg;

    // ****************************************
    // frame characters
    // ****************************************
    localparam logic [7:0] CH_SOF   = 8'h3A;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_SEP   = 8'h2C;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_1     = 8'h31;
    localparam logic [7:0] CH_2     = 8'h32;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] CH_A     = 8'h41;
    localparam logic [7:0] CH_N     = 8'h4E;
    localparam logic [7:0] CH_K     = 8'h4B;

    // ****************************************
    // frame layout
    // ****************************************
    localparam logic [7:0] BATCH_BODY_LEN = 8'h17;
    localparam int         BUF_DEPTH      = 23;
    localparam int         MASK_BASE      = 2;
    localparam int         SEP_IDX        = 12;
    localparam int         STATE_BASE     = 13;
    localparam logic [7:0] NAK_LEN        = 8'h05;
    localparam logic [7:0] STATE_LEN      = 8'h36;
    localparam int         STATE_DATA_LEN = 52;
    localparam int         ANA_BASE       = 1;
    localparam int         ANA_STRIDE     = 6;
    localparam int         IN_BASE        = 25;
    localparam int         OUT_BASE       = 40;
    localparam int         NUM_IN         = 12;
    localparam int         NUM_OUT        = 10;
    localparam int         NUM_ANA        = 4;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned NAK_TIMEOUT_MS  = 1000;
    localparam int unsigned ABORT_TIMEOUT_MS = 5000;
    localparam int unsigned NAK_TIMEOUT_CYC = CLK_HZ / 1000 * NAK_TIMEOUT_MS;

    // ****************************************
    // registers
    // ****************************************
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_OUT    = 4'h4;
    localparam logic [3:0] REG_STAT   = 4'h8;
    localparam int         CTRL_RUN   = 0;
    localparam int         CTRL_ABN   = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int         STAT_CHK   = 0;
    localparam int         STAT_LEN   = 1;
    localparam int         STAT_TMO   = 2;
    localparam int         STAT_RXB   = 8;
    localparam int         STAT_TXB   = 9;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } icfi_bus_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } icfi_byte_t;

    typedef struct packed {
        logic       level_mode;
        logic       switch_on;
        logic [9:0] level;
    } icfi_ana_t;

endpackage

// [icfi_hex2nib.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_hex2nib (
    input  wire logic [7:0] ch,
    output logic      [3:0] nib,
    output logic            ok
);
    wire is_dig = (ch >= icfi_pkg::CH_0) && (ch <= icfi_pkg::CH_9);
    wire is_let = (ch >= icfi_pkg::CH_A) && (ch <= 8'h46);
    wire [7:0] dig = ch - icfi_pkg::CH_0;
    wire [7:0] let_v = ch - icfi_pkg::CH_A + 8'h0A;
    assign nib = is_dig ? dig[3:0] : let_v[3:0];
    assign ok  = is_dig | is_let;
endmodule
`default_nettype wire

// [icfi_nib2hex.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_nib2hex (
    input  wire logic [3:0] nib,
    output logic      [7:0] ch
);
    assign ch = (nib < 4'hA) ? (icfi_pkg::CH_0 + {4'h0, nib})
                             : (icfi_pkg::CH_A + {4'h0, nib} - 8'h0A);
endmodule
`default_nettype wire

// [icfi_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_properties (
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire icfi_pkg::icfi_bus_t  bus,
    input wire logic [31:0]          rd_data,
    input wire icfi_pkg::icfi_byte_t rx,
    input wire logic                 tx_valid,
    input wire logic [7:0]           tx_data,
    input wire logic                 tx_ready,
    input wire logic [9:0]           output_points
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****************************************
    // register port, reply stream and outputs
    // ****************************************
    chk_rd_idle_zero: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
        else $error("read data outside its slot");
    chk_rd_out_mirror: assert property ($past(bus.rd) && $past(bus.addr) == icfi_pkg::REG_OUT
        |-> rd_data == {22'h0, $past(output_points)}) else $error("output word wrong");
    chk_rd_unmapped: assert property ($past(bus.rd) && !($past(bus.addr) inside {4'h0, 4'h4, 4'h8})
        |-> rd_data == 32'h0) else $error("unmapped read not zero");
    chk_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped while stalled");
    chk_tx_sof: assert property ($rose(tx_valid) |-> tx_data == 8'h3A)
        else $error("reply does not open with start byte");
    chk_tx_end_lf: assert property ($fell(tx_valid) |-> $past(tx_data) == 8'h0A)
        else $error("reply does not end with line feed");
    chk_cr_then_lf: assert property (tx_valid && tx_ready && tx_data == 8'h0D |=> tx_data == 8'h0A)
        else $error("carriage return not followed by line feed");
    chk_tx_charset: assert property (tx_valid |-> tx_data inside {8'h0A, 8'h0D, 8'h2C, 8'h3A, 8'h4B,
        8'h4E, [8'h30:8'h39], [8'h41:8'h46]}) else $error("reply byte outside code set");
    chk_out_cause: assert property (!$stable(output_points) |->
        $past(rx.valid) && $past(rx.data) == 8'h0A) else $error("outputs moved without frame end");
    cover property ($rose(tx_valid));
    cover property (tx_valid && !tx_ready);
    cover property (!$stable(output_points));
endmodule
`default_nettype wire

// [icfi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_host_model (
    input  wire logic            clk,
    input  wire logic            slow,
    output var icfi_pkg::icfi_byte_t rx,
    input  wire logic            tx_valid,
    input  wire logic [7:0]      tx_data,
    output logic                 tx_ready
);
    logic [7:0] fr[$];
    logic [7:0] got[$];
    logic       ph = 1'b0;

    initial rx = '0;
    // slow host takes every other cycle, so the reply stream is stalled
    assign tx_ready = slow ? ph : 1'b1;
    always @(posedge clk) begin
        ph <= ~ph;
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    task automatic build(input logic [7:0] b[$], input logic [7:0] ln);
        logic [7:0] x;
        fr = {8'h3A, hx(ln[7:4]), hx(ln[3:0])};
        fr = {fr, b};
        x = 8'h00;
        foreach (fr[i]) x ^= fr[i];
        fr = {fr, hx(x[7:4]), hx(x[3:0]), 8'h0D, 8'h0A};
    endtask

    // idle data shows the inverse of the last byte, never a stale copy
    task automatic send(input logic [7:0] b[$], input logic [7:0] ln, input logic flip, input int cut);
        build(b, ln);
        if (flip) fr[fr.size() - 3] ^= 8'h01;
        for (int i = 0; i < fr.size() - cut; i++) begin
            @(posedge clk) rx <= '{1'b1, fr[i]};
            @(posedge clk) rx <= '{1'b0, ~fr[i]};
        end
    endtask
endmodule
`default_nettype wire

// [icfi_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module icfi_top_tb;
    logic                      clk = 1'b0;
    logic                      rstn = 1'b0;
    icfi_pkg::icfi_bus_t       bus = '0;
    logic [31:0]               rd_data;
    icfi_pkg::icfi_byte_t      rx;
    logic                      tx_valid;
    logic [7:0]                tx_data;
    logic                      tx_ready;
    logic                      slow = 1'b0;
    logic [11:0]               din = 12'hA5C;
    icfi_pkg::icfi_ana_t [3:0] ana = {12'h3DB, 12'h000, 12'h405, 12'hBFF};
    logic [9:0][2:0]           wc = '0;
    logic [9:0]                output_points;
    logic [9:0]                outs = '0;
    logic [7:0]                body[$];
    int                        fails = 0;
    int                        total_checks = 0;

    always #25 clk = ~clk;

    icfi_top #(.NAK_TIMEOUT_CYC(200)) icfi_top_i (.clk(clk), .rstn(rstn), .bus(bus), .rd_data(rd_data),
        .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .digital_input_points(din),
        .analogue_input_channels(ana), .output_wait_code(wc), .output_points(output_points));
    icfi_host_model icfi_host_model_i (.clk(clk), .slow(slow), .rx(rx), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk) bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk) bus <= '0;
        #1 chk("rd_data", e, rd_data);
    endtask

    task automatic mk_batch(input logic [9:0] m, input logic [9:0] s);
        body = {8'h30, 8'h31};
        for (int p = 0; p < 10; p++) body.push_back(8'h30 + 8'(m[p]));
        body.push_back(8'h2C);
        for (int p = 0; p < 10; p++) body.push_back(8'h30 + 8'(s[p]));
    endtask

    // waits for a whole frame, then idles 20 cycles to catch a second frame that starts in that window
    task automatic cmp_reply();
        int k;
        for (k = 0; k < 4000 && !(icfi_host_model_i.got.size() >= icfi_host_model_i.fr.size() && !tx_valid); k++)
            @(posedge clk);
        if (k == 4000) begin
            fails++;
            $display("[ERR] reply expected done seen timeout");
            wrap_up();
        end else begin
            repeat (20) @(posedge clk);
            chk("reply_len", icfi_host_model_i.fr.size(), icfi_host_model_i.got.size());
            foreach (icfi_host_model_i.fr[i]) chk("reply_byte", icfi_host_model_i.fr[i], icfi_host_model_i.got[i]);
            icfi_host_model_i.got.delete();
        end
    endtask

    task automatic s_regs();
        chk("tx_valid", 1'b0, tx_valid);
        chk("output_points", 10'h0, output_points);
        rd(4'h0, 32'h1);
        rd(4'h8, 32'h0);
        wr(4'h4, 32'h3FF);
        rd(4'h4, 32'h0);
        rd(4'hC, 32'h0);
    endtask

    task automatic s_batch();
        logic [9:0]  m[3] = '{10'h3FF, 10'h0A5, 10'h300};
        logic [9:0]  s[3] = '{10'h2B6, 10'h35A, 10'h100};
        logic [31:0] cr[3] = '{32'h1, 32'h0, 32'h3};
        logic [7:0]  cb[3] = '{8'h30, 8'h31, 8'h39};
        int          lv;
        for (int k = 0; k < 3; k++) begin
            wr(4'h0, cr[k]);
            slow <= (k == 1);
            if (k == 2) wc <= {3'h5, 3'h4, 15'h0000, 3'h2, 3'h3, 3'h0};
            mk_batch(m[k], s[k]);
            icfi_host_model_i.send(body, 8'(body.size()), 1'b0, 0);
            outs = (outs & ~m[k]) | (s[k] & m[k]);
            body = {8'h30, 8'h32, cb[k]};
            for (int c = 0; c < 4; c++) begin
                lv = ana[c].level;
                body.push_back(ana[c].level_mode ? 8'h39 : ana[c].switch_on ? 8'h31 : 8'h30);
                body = {body, 8'h30 + 8'(lv / 1000), 8'h30 + 8'(lv / 100 % 10), 8'h30 + 8'(lv / 10 % 10),
                    8'h30 + 8'(lv % 10), 8'h2C};
            end
            for (int i = 0; i < 12; i++) begin
                body.push_back(8'h30 + 8'(din[i]));
                if (i % 4 == 3) body.push_back(8'h2C);
            end
            for (int p = 0; p < 10; p++) begin
                body.push_back(wc[p] != 3'h0 ? 8'h30 + 8'(wc[p]) : 8'h30 + 8'(outs[p]));
                if (p % 4 == 3 && p < 8) body.push_back(8'h2C);
            end
            icfi_host_model_i.build(body, 8'h36);
            cmp_reply();
            chk("output_points", outs, output_points);
            rd(4'h4, {22'h0, outs});
        end
        slow <= 1'b0;
    endtask

    task automatic s_nak(input logic flip, input logic [7:0] dl, input int cut, input int bit_n);
        mk_batch(10'h3FF, 10'h000);
        icfi_host_model_i.send(body, 8'(body.size()) + dl, flip, cut);
        icfi_host_model_i.build({8'h30, 8'h30, 8'h4E, 8'h41, 8'h4B}, 8'h05);
        cmp_reply();
        chk("output_points", outs, output_points);
        rd(4'h8, 32'h1 << bit_n);
        wr(4'h8, 32'h7);
        rd(4'h8, 32'h0);
        // host answers the refusal by sending the same command again
        icfi_host_model_i.send(body, 8'(body.size()), 1'b0, 0);
        outs = 10'h000;
        repeat (200) @(posedge clk);
        chk("resend_reply_len", 32'd61, icfi_host_model_i.got.size());
        chk("output_points", outs, output_points);
        icfi_host_model_i.got.delete();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        s_regs();
        s_batch();
        s_nak(1'b1, 8'h00, 0, 0);
        s_nak(1'b0, 8'h01, 0, 1);
        s_nak(1'b0, 8'h00, 3, 2);
        wrap_up();
    end
endmodule

bind icfi_top icfi_properties icfi_properties_i (.clk(clk), .rstn(rstn), .bus(bus), .rd_data(rd_data),
    .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .output_points(output_points));
`default_nettype wire
